// *** avsm_pkg.sv ***
// Constants, mode codes and carriers for the scaling-link mode and configuration block
package avsm_pkg;
  localparam int          NCH          = 2;
  localparam logic [7:0]  CODE_CFG     = 8'he9;
  localparam logic [7:0]  CODE_ADDR    = 8'hea;
  localparam int          CFG_SLEW     = 0;
  localparam int          CFG_PAY_LO   = 1;
  localparam int          CFG_TX2      = 3;
  localparam int          CFG_STUP     = 4;
  localparam int          CFG_EN       = 7;
  localparam int          ADDR_W       = 4;
  localparam logic [1:0]  PAY_RESET    = 2'h1;
  localparam logic [1:0]  PAY_RSVD     = 2'h0;
  localparam logic [3:0]  ADDR_RESET   = 4'h5;
  localparam logic [15:0] ADDR_FIXED   = 16'h0000;
  localparam int          CLK_PERIOD_NS = 5;
  localparam int          SLEW_TIME_NS  = 30000;
  localparam int          SLEW_CYC      = SLEW_TIME_NS / CLK_PERIOD_NS;
  localparam logic [7:0]  FAST_STEP_MV  = 8'hc8;
  localparam logic [7:0]  SLOW_STEP_MV  = 8'h02;

  typedef enum logic [3:0] {
    MODE_BOOT    = 4'b0001,
    MODE_PMBUS   = 4'b0010,
    MODE_AVS     = 4'b0100,
    MODE_STARTUP = 4'b1000
  } avsm_mode_e;

  typedef struct packed {
    logic       en;
    logic       stup;
    logic       tx2;
    logic [1:0] payload;
    logic       slew;
  } avsm_cfg_s;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        page;
    logic [7:0]  code;
    logic [15:0] wdata;
  } avsm_cmd_s;

  // Voltage width in bits for a payload code
  function automatic logic [4:0] payload_bits(input logic [1:0] code);
    unique case (code)
      2'h1:    payload_bits = 5'h0a;
      2'h2:    payload_bits = 5'h0c;
      2'h3:    payload_bits = 5'h10;
      default: payload_bits = 5'h08;
    endcase
  endfunction
endpackage

// *** avsm_config.sv ***
// Mode selection, configuration and link address registers of the scaling slave port
//
// Behaviour
// - Double-commit bit 0 applies each commit at once; 1 needs two commits; resets 0.
// - Payload code sets voltage width: 01=10 bits default, 10=12, 11=16, 00 reserved.
// - Slew bit 0 selects fast ramp (default), 1 the slowest soft-start ramp.
// - At power-up: enable 0 gives PMBus, 1 gives scaling, with startup bit gives start-up.
// - Without power cycle PMBus persists; scaling moves to start-up when startup bit sets.
// - Start-up with enable 1 returns to scaling when the startup bit clears.
// - Address write with both channels in scaling or start-up mode is acked, dropped, flags fault and alert.
// - Address writes are stored normally when at most one channel is in scaling or start-up mode.
// - Address register holds a 4-bit link address, default 0101, used only on the link.
// - Upper address register bits read fixed zero and writes to them are discarded.
// - Address powers up 0005 and is replaced by the saved configuration at load.
// - Outside start-up mode, enable bit changes the mode only after saving and a power cycle.
// - Startup bit has no effect on mode while in PMBus mode.
// - In start-up mode every command from the link is ignored.
`timescale 1ns/1ps
module avsm_config
  import avsm_pkg::*;
#(
  parameter int SLEW_CYCLES = SLEW_CYC
) (
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire logic                  avs_clk,
  input  wire avsm_cmd_s             cmd,
  output logic                       cmd_ack,
  output logic [15:0]                cmd_rdata,
  input  wire logic                  nvm_load,
  input  wire avsm_cfg_s [NCH-1:0]   nvm_cfg,
  input  wire logic [NCH-1:0][3:0]   nvm_addr,
  output avsm_cfg_s [NCH-1:0]        cfg_out,
  output logic [NCH-1:0][3:0]        addr_out,
  output avsm_mode_e [NCH-1:0]       mode,
  output logic                       oth_set,
  output logic                       smbalert,
  input  wire logic [NCH-1:0]        link_commit,
  output logic [NCH-1:0]             link_ready,
  output logic [NCH-1:0][1:0]        link_payload,
  output logic [NCH-1:0][3:0]        link_addr,
  output logic [NCH-1:0]             commit_apply,
  output logic [NCH-1:0][4:0]        payload_width,
  output logic                       ramp_tick,
  output logic [NCH-1:0][7:0]        ramp_step_mv
);

  initial begin
    if (SLEW_CYCLES < 2 || SLEW_CYCLES > 65535) begin
      $error("SLEW_CYCLES out of range");
    end
  end

  avsm_cfg_s [NCH-1:0]   cfg;
  logic [NCH-1:0][3:0]   addr;
  logic [NCH-1:0]        in_avs;
  logic                  both_avs;
  logic                  wr_cfg;
  logic                  wr_addr;
  logic                  hit;
  logic [NCH-1:0]        tog_link;
  logic [NCH-1:0]        tog_s1;
  logic [NCH-1:0]        tog_s2;
  logic [NCH-1:0]        tog_s3;
  logic [NCH-1:0]        commit_ev;
  logic [NCH-1:0]        pend;
  logic [NCH-1:0]        rdy_s1;
  logic [NCH-1:0][1:0]   pay_s1;
  logic [NCH-1:0][3:0]   adr_s1;
  logic [15:0]           ramp_cnt;

  // Command decode
  assign wr_cfg   = cmd.wr && (cmd.code == CODE_CFG);
  assign wr_addr  = cmd.wr && (cmd.code == CODE_ADDR);
  assign hit      = (cmd.wr || cmd.rd) && (cmd.code == CODE_CFG || cmd.code == CODE_ADDR);
  assign both_avs = &in_avs;
  assign cfg_out  = cfg;
  assign addr_out = addr;

  // Configuration register per channel; loaded values replace reset values
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NCH; i++) begin
        cfg[i] <= '{en: 1'b0, stup: 1'b0, tx2: 1'b0, payload: PAY_RESET, slew: 1'b0};
      end
    end else if (nvm_load) begin
      cfg <= nvm_cfg;
    end else if (wr_cfg) begin
      cfg[cmd.page].en   <= cmd.wdata[CFG_EN];
      cfg[cmd.page].stup <= cmd.wdata[CFG_STUP];
      cfg[cmd.page].tx2  <= cmd.wdata[CFG_TX2];
      cfg[cmd.page].slew <= cmd.wdata[CFG_SLEW];
      if (cmd.wdata[CFG_PAY_LO+1:CFG_PAY_LO] != PAY_RSVD) begin
        cfg[cmd.page].payload <= cmd.wdata[CFG_PAY_LO+1:CFG_PAY_LO];
      end
    end
  end

  // Link address register, write-protected while both channels run scaling or start-up mode
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NCH; i++) begin
        addr[i] <= ADDR_RESET;
      end
    end else if (nvm_load) begin
      addr <= nvm_addr;
    end else if (wr_addr && !both_avs) begin
      addr[cmd.page] <= cmd.wdata[ADDR_W-1:0];
    end
  end

  // Refused address write raises the other-fault flag and the alert
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      oth_set  <= 1'b0;
      smbalert <= 1'b0;
    end else begin
      oth_set  <= wr_addr && both_avs && !nvm_load;
      smbalert <= wr_addr && both_avs && !nvm_load;
    end
  end

  // Read data and acknowledge, one cycle after the command
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmd_ack   <= 1'b0;
      cmd_rdata <= 16'h0000;
    end else begin
      cmd_ack <= hit;
      if (cmd.rd && cmd.code == CODE_ADDR) begin
        cmd_rdata <= ADDR_FIXED | {12'h000, addr[cmd.page]};
      end else if (cmd.rd && cmd.code == CODE_CFG) begin
        cmd_rdata <= {8'h00, cfg[cmd.page].en, 2'b00, cfg[cmd.page].stup,
                      cfg[cmd.page].tx2, cfg[cmd.page].payload, cfg[cmd.page].slew};
      end else begin
        cmd_rdata <= 16'h0000;
      end
    end
  end

  // Per-channel mode machine, commit path and link crossings
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    avsm_mode_e next_mode;

    assign in_avs[c]        = (mode[c] == MODE_AVS) || (mode[c] == MODE_STARTUP);
    assign payload_width[c] = payload_bits(cfg[c].payload);
    assign ramp_step_mv[c]  = cfg[c].slew ? SLOW_STEP_MV : FAST_STEP_MV;

    // Mode transitions; power-cycle choice only from the boot state
    always_comb begin
      next_mode = mode[c];
      unique case (mode[c])
        MODE_BOOT: begin
          if (nvm_load) begin
            if (!nvm_cfg[c].en) begin
              next_mode = MODE_PMBUS;
            end else if (nvm_cfg[c].stup) begin
              next_mode = MODE_STARTUP;
            end else begin
              next_mode = MODE_AVS;
            end
          end
        end
        MODE_PMBUS: begin
          next_mode = MODE_PMBUS;
        end
        MODE_AVS: begin
          if (cfg[c].stup) begin
            next_mode = MODE_STARTUP;
          end
        end
        MODE_STARTUP: begin
          if (cfg[c].en && !cfg[c].stup) begin
            next_mode = MODE_AVS;
          end
        end
        default: next_mode = MODE_BOOT;
      endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        mode[c] <= MODE_BOOT;
      end else begin
        mode[c] <= next_mode;
      end
    end

    // Link side: each commit flips a toggle on the link clock
    always_ff @(posedge avs_clk or negedge rstn) begin
      if (!rstn) begin
        tog_link[c] <= 1'b0;
      end else if (link_commit[c]) begin
        tog_link[c] <= ~tog_link[c];
      end
    end

    // Toggle brought to the device clock, then edge-detected
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        tog_s1[c] <= 1'b0;
        tog_s2[c] <= 1'b0;
        tog_s3[c] <= 1'b0;
      end else begin
        tog_s1[c] <= tog_link[c];
        tog_s2[c] <= tog_s1[c];
        tog_s3[c] <= tog_s2[c];
      end
    end
    assign commit_ev[c] = tog_s2[c] ^ tog_s3[c];

    // Double-commit check; commits outside scaling mode are dropped
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        pend[c]         <= 1'b0;
        commit_apply[c] <= 1'b0;
      end else if (mode[c] != MODE_AVS || !cfg[c].tx2) begin
        pend[c]         <= 1'b0;
        commit_apply[c] <= commit_ev[c] && (mode[c] == MODE_AVS);
      end else if (commit_ev[c]) begin
        pend[c]         <= ~pend[c];
        commit_apply[c] <= pend[c];
      end else begin
        commit_apply[c] <= 1'b0;
      end
    end

    // Quasi-static settings to the link clock through two flip-flops
    always_ff @(posedge avs_clk or negedge rstn) begin
      if (!rstn) begin
        rdy_s1[c]       <= 1'b0;
        pay_s1[c]       <= PAY_RESET;
        adr_s1[c]       <= ADDR_RESET;
        link_ready[c]   <= 1'b0;
        link_payload[c] <= PAY_RESET;
        link_addr[c]    <= ADDR_RESET;
      end else begin
        rdy_s1[c]       <= (mode[c] == MODE_AVS);
        pay_s1[c]       <= cfg[c].payload;
        adr_s1[c]       <= addr[c];
        link_ready[c]   <= rdy_s1[c];
        link_payload[c] <= pay_s1[c];
        link_addr[c]    <= adr_s1[c];
      end
    end
  end

  // Reference ramp interval timer, one tick per ramp period
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ramp_cnt  <= 16'h0000;
      ramp_tick <= 1'b0;
    end else if (ramp_cnt == 16'(SLEW_CYCLES - 1)) begin
      ramp_cnt  <= 16'h0000;
      ramp_tick <= 1'b1;
    end else begin
      ramp_cnt  <= ramp_cnt + 16'h0001;
      ramp_tick <= 1'b0;
    end
  end

endmodule // avsm_config

// *** avsm_props.sv ***
// Checker of the mode, commit and register rules
`timescale 1ns/1ps
module avsm_props
  import avsm_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 rstn,
  input wire avsm_cmd_s            cmd,
  input wire logic                 cmd_ack,
  input wire logic [15:0]          cmd_rdata,
  input wire logic                 nvm_load,
  input wire avsm_cfg_s [NCH-1:0]  nvm_cfg,
  input wire avsm_cfg_s [NCH-1:0]  cfg_out,
  input wire avsm_mode_e [NCH-1:0] mode,
  input wire logic                 oth_set,
  input wire logic                 smbalert,
  input wire logic [NCH-1:0]       commit_apply,
  input wire logic [NCH-1:0][4:0]  payload_width,
  input wire logic [NCH-1:0][7:0]  ramp_step_mv
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Address register access
  property p_ack; cmd.wr && cmd.code == CODE_ADDR && !nvm_load |=> cmd_ack; endproperty
  a_ack: assert property (p_ack) else $error("address write not acked");
  property p_lock; cmd.wr && cmd.code == CODE_ADDR && !nvm_load
    && mode[0] inside {MODE_AVS, MODE_STARTUP} && mode[1] inside {MODE_AVS, MODE_STARTUP}
    |-> ##[1:2] oth_set; endproperty
  a_lock: assert property (p_lock) else $error("locked write not flagged");
  property p_open; cmd.wr && cmd.code == CODE_ADDR && mode[1] == MODE_PMBUS
    |=> !oth_set ##1 !oth_set; endproperty
  a_open: assert property (p_open) else $error("open write flagged");
  property p_alert; smbalert == oth_set; endproperty
  a_alert: assert property (p_alert) else $error("alert differs from flag");
  property p_upper; cmd.rd && cmd.code == CODE_ADDR |=> cmd_rdata[15:4] == 12'h000; endproperty
  a_upper: assert property (p_upper) else $error("upper address bits set");
  // Mode machine
  property p_boot; nvm_load && mode[0] == MODE_BOOT |=> mode[0] == (!$past(nvm_cfg[0].en) ?
    MODE_PMBUS : $past(nvm_cfg[0].stup) ? MODE_STARTUP : MODE_AVS); endproperty
  a_boot: assert property (p_boot) else $error("wrong power-up mode");
  property p_pm; mode[1] == MODE_PMBUS |=> mode[1] == MODE_PMBUS; endproperty
  a_pm: assert property (p_pm) else $error("left PMBus mode");
  property p_up; mode[0] == MODE_AVS && cfg_out[0].stup |=> mode[0] == MODE_STARTUP; endproperty
  a_up: assert property (p_up) else $error("start-up not entered");
  property p_back; mode[0] == MODE_STARTUP && cfg_out[0].en && !cfg_out[0].stup
    |=> mode[0] == MODE_AVS; endproperty
  a_back: assert property (p_back) else $error("start-up not left");
  property p_apply; commit_apply[0] |-> $past(mode[0]) == MODE_AVS; endproperty
  a_apply: assert property (p_apply) else $error("commit outside scaling mode");
  // Configuration fields
  property p_width; cfg_out[1].payload != PAY_RSVD && payload_width[1] == (cfg_out[1].payload
    == 2'h1 ? 5'h0a : cfg_out[1].payload == 2'h2 ? 5'h0c : 5'h10); endproperty
  a_width: assert property (p_width) else $error("wrong payload width");
  property p_step; ramp_step_mv[0] == (cfg_out[0].slew ? SLOW_STEP_MV : FAST_STEP_MV); endproperty
  a_step: assert property (p_step) else $error("wrong ramp step");
endmodule // avsm_props

bind avsm_config avsm_props u_props (.clk, .rstn, .cmd, .cmd_ack, .cmd_rdata, .nvm_load,
  .nvm_cfg, .cfg_out, .mode, .oth_set, .smbalert, .commit_apply, .payload_width, .ramp_step_mv);

// *** avsm_host.sv ***
// Link master model issuing commit writes
`timescale 1ns/1ps
module avsm_host
  import avsm_pkg::*;
(
  input  wire logic      avs_clk,
  output logic [NCH-1:0] link_commit
);
  initial link_commit = '0;
  // One commit pulse, then a quiet link cycle for spacing
  task automatic commit(input int c);
    @(negedge avs_clk) link_commit[c] = 1'b1;
    @(negedge avs_clk) link_commit[c] = 1'b0;
    @(negedge avs_clk);
  endtask
endmodule // avsm_host

// *** tb_top.sv ***
// Self-checking bench of the scaling mode and configuration block
`timescale 1ns/1ps
module tb_top
  import avsm_pkg::*;
;
  logic                 clk = 1'b0, avs_clk = 1'b0, rstn = 1'b0, nvm_load = 1'b0;
  avsm_cmd_s            cmd = '0;
  avsm_cfg_s [NCH-1:0]  nvm_cfg = '0, cfg_out;
  logic [NCH-1:0][3:0]  nvm_addr = '0, addr_out, link_addr;
  logic                 cmd_ack, oth_set, smbalert, ramp_tick;
  logic [15:0]          cmd_rdata;
  avsm_mode_e [NCH-1:0] mode;
  logic [NCH-1:0]       link_commit, link_ready, commit_apply;
  logic [NCH-1:0][1:0]  link_payload;
  logic [NCH-1:0][4:0]  payload_width;
  logic [NCH-1:0][7:0]  ramp_step_mv;
  int                   n_mismatch = 0, checks = 0, n_oth = 0;

  // Device clock and a link clock offset in phase
  always #2.5 clk = ~clk;
  initial begin
    #1.3;
    forever #62.5 avs_clk = ~avs_clk;
  end
  avsm_config #(.SLEW_CYCLES(8)) DUT (.clk, .rstn, .avs_clk, .cmd, .cmd_ack, .cmd_rdata,
    .nvm_load, .nvm_cfg, .nvm_addr, .cfg_out, .addr_out, .mode, .oth_set, .smbalert,
    .link_commit, .link_ready, .link_payload, .link_addr, .commit_apply, .payload_width,
    .ramp_tick, .ramp_step_mv);
  avsm_host u_host (.avs_clk, .link_commit);
  // Counts refused-write flags
  always @(posedge clk) if (oth_set === 1'b1) n_oth++;

  task automatic chk(input logic [15:0] got, exp);
    checks++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  // Reset held over twelve link cycles so both domains see it
  task automatic do_reset;
    rstn = 1'b0;
    repeat (12) @(negedge avs_clk);
    @(negedge clk);
    rstn = 1'b1;
  endtask
  // One register access, answer checked after the ack edge
  // The acknowledge stands only in the cycle after the request edge, so it is judged there
  task automatic bus(input logic wr, pg, input logic [7:0] code, input logic [15:0] wd, exp);
    @(negedge clk);
    cmd = '{wr, !wr, pg, code, wd};
    @(negedge clk);
    chk(cmd_ack, 1'b1);
    if (!wr) chk(cmd_rdata, exp);
    cmd = '0;
  endtask
  task automatic nvm(input avsm_cfg_s c0, c1, input logic [7:0] a);
    @(negedge clk);
    nvm_cfg = {c1, c0};
    nvm_addr = a;
    nvm_load = 1'b1;
    @(negedge clk);
    nvm_load = 1'b0;
  endtask
  // Link commit, watching whether it is applied
  task automatic commit(input int c, input logic exp);
    logic seen = 1'b0;
    fork
      u_host.commit(c);
      repeat (80) @(negedge clk) if (commit_apply[c] === 1'b1) seen = 1'b1;
    join
    chk(seen, exp);
  endtask

  task automatic t_reset;
    int n_tick = 0;
    chk(mode[0], MODE_BOOT);
    // Ramp interval timer: two ticks in any sixteen cycles at eight cycles per period
    repeat (16) @(negedge clk) if (ramp_tick === 1'b1) n_tick++;
    chk(16'(n_tick), 16'h0002);
    bus(0, 0, CODE_CFG, 0, 16'h0002);
    bus(0, 0, CODE_ADDR, 0, 16'h0005);
    chk(ramp_step_mv[0], FAST_STEP_MV);
    commit(0, 0);
  endtask
  // One channel scaling with double commit, the other on PMBus
  task automatic t_one;
    nvm(6'h2a, 6'h02, 8'h53);
    chk(mode[0], MODE_AVS);
    chk(mode[1], MODE_PMBUS);
    bus(0, 0, CODE_ADDR, 0, 16'h0003);
    bus(1, 1, CODE_ADDR, 16'hfffa, 0);
    bus(0, 1, CODE_ADDR, 0, 16'h000a);
    bus(1, 1, CODE_CFG, 16'h0096, 0);
    @(negedge clk);
    chk(mode[1], MODE_PMBUS);
    chk(payload_width[1], 5'h10);
    bus(1, 1, CODE_CFG, 16'h0084, 0);
    chk(payload_width[1], 5'h0c);
    bus(1, 1, CODE_CFG, 16'h0090, 0);
    bus(0, 1, CODE_CFG, 0, 16'h0094);
    commit(0, 0);
    commit(0, 1);
    chk(16'(n_oth), 16'h0000);
  endtask
  // Both channels scaling: address lock, slew, start-up entry and exit
  task automatic t_both;
    do_reset;
    nvm(6'h22, 6'h22, 8'h55);
    bus(1, 0, CODE_ADDR, 16'h0009, 0);
    bus(0, 0, CODE_ADDR, 0, 16'h0005);
    chk(16'(n_oth), 16'h0001);
    commit(0, 1);
    bus(1, 0, CODE_CFG, 16'h0083, 0);
    chk(ramp_step_mv[0], SLOW_STEP_MV);
    bus(1, 0, CODE_CFG, 16'h0092, 0);
    @(negedge clk);
    chk(mode[0], MODE_STARTUP);
    commit(0, 0);
    bus(1, 0, CODE_CFG, 16'h0082, 0);
    @(negedge clk);
    chk(mode[0], MODE_AVS);
    // Link-side copies settle after two link clock edges
    repeat (3) @(negedge avs_clk);
    @(negedge clk);
    chk(link_ready[0], 1'b1);
    chk(link_addr[0], 16'h0005);
    chk(link_payload[0], 16'h0001);
    chk(addr_out[1], 16'h0005);
    chk(16'(cfg_out[0]), 16'h0022);
  endtask

  task automatic end_sim;
    if (n_mismatch == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    do_reset;
    t_reset;
    t_one;
    t_both;
    end_sim;
  end
  // Watchdog
  initial begin
    #100000;
    n_mismatch++;
    end_sim;
  end
endmodule // tb_top
